//--- rtl/vip_host.sv
// host controller: polls the probe core and relays software commands
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module vip_host #(
  parameter int N_IN = 8,
  parameter int POLL_UNIT_CYC = vip_pkg::POLL_BASE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link to the core
  vip_link_if.host link,
  // software register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [31:0] rdata,
  // interrupt
  output logic irq
);

  // ==========================================================
  // parameter checks
  generate
    if (N_IN < 1 || N_IN > 10) begin : g_bad_in
      $error("vip_host: N_IN must be 1 to 10");
    end
    if (POLL_UNIT_CYC < 2) begin : g_bad_poll
      $error("vip_host: POLL_UNIT_CYC must be at least 2");
    end
  endgenerate

  localparam int UW = $clog2(POLL_UNIT_CYC);

  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0] rate;
    logic [1:0] pers;
    logic [1:0] mask;
    logic [1:0] stat;
    logic [15:0] cdata;
    logic cmd_valid;
    vip_pkg::vip_op_t op;
    logic [7:0] idx;
    logic [15:0] odata;
    logic [UW-1:0] unit_cnt;
    logic [4:0] mult_cnt;
    logic poll_pend;
    logic [N_IN-1:0] value;
    logic [3*N_IN-1:0] show;
    logic [N_IN-1:0][6:0] pcnt;
    logic [31:0] rdata;
  } vip_host_st_t;

  vip_host_st_t s_q;
  vip_host_st_t s_d;

  logic wr_cmd;
  logic [2:0] act;
  logic [6:0] limit;
  logic [N_IN-1:0] r_val;
  logic [N_IN-1:0] r_rise;
  logic [N_IN-1:0] r_fall;
  logic [N_IN-1:0] r_aact;

  assign wr_cmd = we && addr == vip_pkg::REG_CMD;
  assign {r_val, r_rise, r_fall, r_aact} = link.rsp_data;

  always_comb begin
    case (vip_pkg::vip_pers_t'(s_q.pers))
      vip_pkg::PERS_LONG: limit = 7'(vip_pkg::PERSIST_LONG);
      default: limit = 7'(vip_pkg::PERSIST_SHORT);
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    act = 3'h0;
    s_d.cmd_valid = 1'b0;

    // poll timer; manual mode leaves it idle
    if (s_q.rate < vip_pkg::RATE_MANUAL) begin
      if (s_q.unit_cnt == UW'(POLL_UNIT_CYC - 1)) begin
        s_d.unit_cnt = '0;
        if (s_q.mult_cnt == vip_pkg::vip_rate_mult(s_q.rate) - 5'h01) begin
          s_d.mult_cnt = 5'h00;
          s_d.poll_pend = 1'b1;
        end else begin
          s_d.mult_cnt = s_q.mult_cnt + 5'h01;
        end
      end else begin
        s_d.unit_cnt = s_q.unit_cnt + UW'(1);
      end
    end

    // register writes
    if (we) begin
      case (addr)
        vip_pkg::REG_CTRL: begin
          s_d.rate = wdata[vip_pkg::CTRL_RATE_LSB +: 3];
          s_d.pers = wdata[vip_pkg::CTRL_PERS_LSB +: 2];
          s_d.unit_cnt = '0;
          s_d.mult_cnt = 5'h00;
        end
        vip_pkg::REG_DATA: s_d.cdata = wdata[15:0];
        vip_pkg::REG_MASK: s_d.mask = wdata[1:0];
        default: begin
        end
      endcase
    end

    // software command wins the slot; a due poll waits for a cycle with no command
    if (wr_cmd) begin
      s_d.cmd_valid = 1'b1;
      s_d.op = vip_pkg::vip_op_t'(wdata[vip_pkg::CMD_OP_LSB +: 4]);
      s_d.idx = wdata[vip_pkg::CMD_IDX_LSB +: 8];
      s_d.odata = s_q.cdata;
    end else if (s_q.poll_pend) begin
      s_d.cmd_valid = 1'b1;
      s_d.op = vip_pkg::OP_QUERY;
      s_d.idx = 8'h00;
      s_d.odata = 16'h0000;
      s_d.poll_pend = 1'b0;
    end

    // status: a read clears, a new event in the same cycle wins
    if (re && addr == vip_pkg::REG_STAT) begin
      s_d.stat = 2'h0;
    end

    // answers and persistence of shown activity
    if (link.rsp_valid) begin
      s_d.value = r_val;
      s_d.stat[vip_pkg::ST_SAMPLE] = 1'b1;
      if (|{r_rise, r_fall, r_aact}) begin
        s_d.stat[vip_pkg::ST_ACT] = 1'b1;
      end
      for (int i = 0; i < N_IN; i++) begin
        act = {r_rise[i], r_fall[i], r_aact[i]};
        if (act != 3'h0) begin
          s_d.show[3*i +: 3] = act;
          s_d.pcnt[i] = limit;
        end else if (s_q.pers != vip_pkg::PERS_INF) begin
          if (s_q.pcnt[i] > 7'h01) begin
            s_d.pcnt[i] = s_q.pcnt[i] - 7'h01;
          end else begin
            s_d.pcnt[i] = 7'h00;
            s_d.show[3*i +: 3] = 3'h0;
          end
        end
      end
    end

    // a clear command also wipes what is shown
    if (s_q.cmd_valid && s_q.op == vip_pkg::OP_CLEAR) begin
      s_d.show = '0;
      s_d.pcnt = '0;
    end

    // read data, one cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (re) begin
      case (addr)
        vip_pkg::REG_CTRL: begin
          s_d.rdata[vip_pkg::CTRL_RATE_LSB +: 3] = s_q.rate;
          s_d.rdata[vip_pkg::CTRL_PERS_LSB +: 2] = s_q.pers;
        end
        vip_pkg::REG_DATA: s_d.rdata[15:0] = s_q.cdata;
        vip_pkg::REG_STAT: s_d.rdata[1:0] = s_q.stat;
        vip_pkg::REG_MASK: s_d.rdata[1:0] = s_q.mask;
        vip_pkg::REG_VALUE: s_d.rdata[N_IN-1:0] = s_q.value;
        vip_pkg::REG_SHOW: s_d.rdata[3*N_IN-1:0] = s_q.show;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.rate <= vip_pkg::RATE_RST;
      s_q.pers <= vip_pkg::PERS_RST;
      s_q.mask <= vip_pkg::MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign link.cmd_valid = s_q.cmd_valid;
  assign link.cmd_op = s_q.op;
  assign link.cmd_idx = s_q.idx;
  assign link.cmd_data = s_q.odata;
  assign rdata = s_q.rdata;
  assign irq = |(s_q.stat & s_q.mask);

endmodule

//--- shared/vip_pkg.sv
// shared constants and types for the virtual i/o probe core and its host
package vip_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int POLL_BASE_MS = 250;
  localparam int POLL_BASE_CYC = POLL_BASE_MS * (CLK_HZ / 1000);
  localparam int TRAIN_LEN = 16;
  localparam int PERSIST_LONG = 80;
  localparam int PERSIST_SHORT = 8;

  // ==========================================================
  // link commands
  typedef enum logic [3:0] {
    OP_NOP,
    OP_QUERY,
    OP_CLEAR,
    OP_SET,
    OP_UPDATE,
    OP_LOAD,
    OP_RUN,
    OP_PULSE,
    OP_RESET
  } vip_op_t;

  // set command data bits
  localparam int SET_VAL_BIT = 0;
  localparam int SET_BTN_BIT = 1;
  localparam int SET_LOW_BIT = 2;

  // ==========================================================
  // host register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_VALUE = 8'h14;
  localparam logic [7:0] REG_SHOW = 8'h18;

  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_PERS_LSB = 3;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IDX_LSB = 8;
  localparam int ST_SAMPLE = 0;
  localparam int ST_ACT = 1;

  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic [2:0] RATE_MANUAL = 3'h5;
  localparam logic [1:0] PERS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  typedef enum logic [1:0] {
    PERS_INF,
    PERS_LONG,
    PERS_SHORT
  } vip_pers_t;

  // poll interval in units of the base period
  function automatic logic [4:0] vip_rate_mult(input logic [2:0] rate);
    case (rate)
      3'h0: vip_rate_mult = 5'h01;
      3'h1: vip_rate_mult = 5'h02;
      3'h2: vip_rate_mult = 5'h04;
      3'h3: vip_rate_mult = 5'h08;
      default: vip_rate_mult = 5'h14;
    endcase
  endfunction

endpackage

//--- shared/vip_link_if.sv
// link between the probe core and its host controller
`timescale 1ns/10ps
interface vip_link_if #(parameter int N_IN = 8) ();
  logic cmd_valid;
  vip_pkg::vip_op_t cmd_op;
  logic [7:0] cmd_idx;
  logic [15:0] cmd_data;
  logic rsp_valid;
  logic [4*N_IN-1:0] rsp_data;

  modport core (
    input cmd_valid, cmd_op, cmd_idx, cmd_data,
    output rsp_valid, rsp_data
  );
  modport host (
    output cmd_valid, cmd_op, cmd_idx, cmd_data,
    input rsp_valid, rsp_data
  );
endinterface

//--- rtl/vip_core.sv
// probe core: samples and records input activity, drives outputs
`timescale 1ns/10ps
// How it works
// - query returns value plus activity since last
// - activity history restarts at every query
// - synchronous rise, fall or both are flagged
// - activity tells synchronous from asynchronous catch
// - clear command drops activity of all inputs
// - sync outputs play 16-value sequence once
// - sequences only on outputs declared synchronous
// - single pulse drives a sync output not in a sequence active one cycle
// - button drives active level while held
// - host sends changes; batch skips sequence outputs
// - reset command zeroes outputs and sequences
// - host polls inputs on selectable timer
// - manual mode polls only on explicit sample
// - host keeps activity shown per persistence
module vip_core #(
  parameter int N_IN = 8,
  parameter int N_OUT = 8,
  parameter logic [15:0] SYNC_MASK = 16'hffff
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link to the host
  vip_link_if.core link,
  // probed design signals
  input wire logic [N_IN-1:0] probe_in,
  // driven design signals
  output logic [N_OUT-1:0] probe_out
);

  // ==========================================================
  // parameter checks
  generate
    if (N_IN < 1 || N_IN > 10) begin : g_bad_in
      $error("vip_core: N_IN must be 1 to 10");
    end
    if (N_OUT < 1 || N_OUT > 16) begin : g_bad_out
      $error("vip_core: N_OUT must be 1 to 16");
    end
  endgenerate

  // ==========================================================
  // state
  typedef struct packed {
    logic [N_IN-1:0] last;
    logic [N_IN-1:0] qval;
    logic [N_IN-1:0] rise;
    logic [N_IN-1:0] fall;
    logic [N_IN-1:0] aact;
    logic [N_OUT-1:0] base;
    logic [N_OUT-1:0] seqm;
    logic [N_OUT-1:0] run;
    logic [N_OUT-1:0] outv;
    logic [N_OUT-1:0][vip_pkg::TRAIN_LEN-1:0] train;
    logic [3:0] step;
    logic rsp_valid;
    logic [4*N_IN-1:0] rsp_data;
  } vip_core_st_t;

  vip_core_st_t s_q;
  vip_core_st_t s_d;

  logic [N_OUT-1:0] sync_m;
  logic [N_IN-1:0] ev_rise;
  logic [N_IN-1:0] ev_fall;
  logic [N_IN-1:0] ev_async;
  logic [N_OUT-1:0] cmd_m;
  logic [N_OUT-1:0] pulse;
  logic [N_OUT-1:0] data_m;

  assign sync_m = SYNC_MASK[N_OUT-1:0];
  assign data_m = link.cmd_data[N_OUT-1:0];

  // ==========================================================
  // activity detection
  // every clock edge compares with the previous sample; the
  // asynchronous flag compares with the level seen at the last query or clear,
  // so it still reports a change the clock sampling never saw twice
  assign ev_rise = probe_in & ~s_q.last;
  assign ev_fall = ~probe_in & s_q.last;
  assign ev_async = probe_in ^ s_q.qval;

  // one-hot of the addressed output
  always_comb begin
    for (int i = 0; i < N_OUT; i++) begin
      cmd_m[i] = (link.cmd_idx == 8'(i));
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    pulse = '0;
    s_d.rsp_valid = 1'b0;
    s_d.last = probe_in;
    s_d.rise = s_q.rise | ev_rise;
    s_d.fall = s_q.fall | ev_fall;
    s_d.aact = s_q.aact | ev_async;

    // sequence playback, one value per clock
    if (|s_q.run) begin
      s_d.step = s_q.step + 4'h1;
      if (s_q.step == 4'(vip_pkg::TRAIN_LEN - 1)) begin
        for (int i = 0; i < N_OUT; i++) begin
          if (s_q.run[i]) begin
            s_d.base[i] = s_q.train[i][vip_pkg::TRAIN_LEN-1];
          end
        end
        s_d.run = '0;
      end
    end

    if (link.cmd_valid) begin
      case (link.cmd_op)
        vip_pkg::OP_QUERY: begin
          // this cycle's events ride in the answer, then history restarts
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data = {probe_in, s_d.rise, s_d.fall, s_d.aact};
          s_d.rise = '0;
          s_d.fall = '0;
          s_d.aact = '0;
          s_d.qval = probe_in;
        end
        vip_pkg::OP_CLEAR: begin
          // events of this very cycle survive the clear
          s_d.rise = ev_rise;
          s_d.fall = ev_fall;
          s_d.aact = ev_rise | ev_fall;
          s_d.qval = probe_in;
        end
        vip_pkg::OP_SET: begin
          for (int i = 0; i < N_OUT; i++) begin
            if (cmd_m[i]) begin
              s_d.seqm[i] = 1'b0;
              s_d.run[i] = 1'b0;
              if (link.cmd_data[vip_pkg::SET_BTN_BIT]) begin
                s_d.base[i] = link.cmd_data[vip_pkg::SET_VAL_BIT]
                  ^ link.cmd_data[vip_pkg::SET_LOW_BIT];
              end else begin
                s_d.base[i] = link.cmd_data[vip_pkg::SET_VAL_BIT];
              end
            end
          end
        end
        vip_pkg::OP_UPDATE: begin
          s_d.base = (s_q.base & s_q.seqm) | (data_m & ~s_q.seqm);
        end
        vip_pkg::OP_LOAD: begin
          for (int i = 0; i < N_OUT; i++) begin
            if (cmd_m[i] && sync_m[i]) begin
              s_d.train[i] = link.cmd_data;
              s_d.seqm[i] = 1'b1;
            end
          end
        end
        vip_pkg::OP_RUN: begin
          // a new run restarts every sequence it selects from its first value and stops the others
          s_d.run = data_m & sync_m & s_q.seqm;
          s_d.step = 4'h0;
        end
        vip_pkg::OP_PULSE: begin
          pulse = data_m & sync_m & ~s_q.run;
          s_d.base = s_q.base & ~pulse;
        end
        vip_pkg::OP_RESET: begin
          s_d.base = '0;
          s_d.run = '0;
          s_d.train = '0;
        end
        default: begin
        end
      endcase
    end

    // output drive: running sequence, else pulse, else held level
    for (int i = 0; i < N_OUT; i++) begin
      if (s_d.run[i] && s_q.run[i]) begin
        s_d.outv[i] = s_q.train[i][s_q.step];
      end else begin
        s_d.outv[i] = pulse[i] | s_d.base[i];
      end
    end
    // the last sequence value is driven from the train even if a command changes base in the same cycle
    if (|s_q.run && s_q.step == 4'(vip_pkg::TRAIN_LEN - 1)) begin
      for (int i = 0; i < N_OUT; i++) begin
        if (s_q.run[i] && !(link.cmd_valid && link.cmd_op ==
            vip_pkg::OP_RUN)) begin
          s_d.outv[i] = s_q.train[i][s_q.step];
        end
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign probe_out = s_q.outv;
  assign link.rsp_valid = s_q.rsp_valid;
  assign link.rsp_data = s_q.rsp_data;

endmodule

//--- bench/vip_asserts.sv
// concurrent checks on the link between the probe core and its host
`timescale 1ns/10ps
module vip_asserts #(
  parameter int N_IN = 8
) (
  // clock and reset
  input logic mclk,
  input logic rst,
  // link signals
  input logic cmd_valid,
  input vip_pkg::vip_op_t cmd_op,
  input logic [7:0] cmd_idx,
  input logic [15:0] cmd_data,
  input logic rsp_valid,
  input logic [4*N_IN-1:0] rsp_data
);
  // ==========================================================
  // helper logic
  logic q_now;
  logic [N_IN-1:0] val, rise, fall, chg;
  logic [N_IN-1:0] ref_q;
  logic ref_ok_q;
  assign q_now = cmd_valid && cmd_op == vip_pkg::OP_QUERY;
  assign {val, rise, fall, chg} = rsp_data;
  // a clear moves the reference to an unseen level, so forget it
  always_ff @(posedge mclk) begin
    if (rst || (cmd_valid && cmd_op == vip_pkg::OP_CLEAR)) begin
      ref_ok_q <= 1'b0;
    end else if (rsp_valid) begin
      ref_ok_q <= 1'b1;
    end
    if (rsp_valid) begin
      ref_q <= val;
    end
  end

  // ==========================================================
  // assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_query_answer: assert property (
    q_now |=> rsp_valid) else $error("query got no answer");
  chk_answer_cause: assert property (
    rsp_valid |-> $past(q_now)) else $error("answer without query");
  chk_back_to_back: assert property (
    q_now ##1 q_now |-> rsp_valid [*2]) else $error("lost answer");
  chk_rise_level: assert property (
    rsp_valid |-> (rise & ~fall & ~val) == '0)
    else $error("rise only but value low");
  chk_fall_level: assert property (
    rsp_valid |-> (fall & ~rise & val) == '0)
    else $error("fall only but value high");
  chk_sync_async: assert property (
    rsp_valid |-> ((rise ^ fall) & ~chg) == '0)
    else $error("level change without async flag");
  chk_history_restart: assert property (
    rsp_valid && ref_ok_q |-> ((val ^ ref_q) & ~chg) == '0)
    else $error("change since last query not flagged");
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !rsp_valid && !cmd_valid) else $error("link busy in reset");
endmodule

//--- bench/tb_top.sv
// self-checking bench: host and probe core joined over their link
`timescale 1ns/10ps
module tb_top;
  // short poll unit keeps the timer tests brief
  localparam int UNIT = 8;
  localparam int NI = 8;
  localparam int NO = 8;
  localparam logic [15:0] SEQ = 16'hb38d;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [7:0] probe_in = 8'h00;
  logic [7:0] probe_out;
  logic exp_b;
  int mult[5] = '{1, 2, 4, 8, 20};
  int failures = 0;
  int cmp_count = 0;

  // ==========================================================
  // instances
  vip_link_if #(.N_IN(NI)) link ();
  vip_host #(.N_IN(NI), .POLL_UNIT_CYC(UNIT)) vip_host_inst (.mclk(mclk),
    .rst(rst), .link(link), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .irq(irq));
  // output 7 is asynchronous
  vip_core #(.N_IN(NI), .N_OUT(NO), .SYNC_MASK(16'h007f)) vip_core_inst (
    .mclk(mclk), .rst(rst), .link(link), .probe_in(probe_in),
    .probe_out(probe_out));
  vip_asserts #(.N_IN(NI)) vip_asserts_inst (.mclk(mclk), .rst(rst),
    .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op),
    .cmd_idx(link.cmd_idx), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

  always #20 mclk = ~mclk;

  // ==========================================================
  // tasks: each starts just after an edge; strobes stay until idle
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    re <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    addr <= a;
    re <= 1'b1;
    we <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rdata, exp);
  endtask
  task automatic idle(input int n);
    we <= 1'b0;
    re <= 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // returns in the cycle after the core took the command
  task automatic cmd(input vip_pkg::vip_op_t op, input logic [7:0] i,
                     input logic [15:0] d);
    wr(vip_pkg::REG_DATA, {16'h0000, d});
    wr(vip_pkg::REG_CMD, {16'h0000, i, 4'h0, op});
    idle(1);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    idle(1);
    rdchk(vip_pkg::REG_CTRL, 32'h0000_0000);
    rdchk(vip_pkg::REG_MASK, 32'h0000_0000);
    wr(vip_pkg::REG_MASK, 32'h0000_0001);
    for (int r = 0; r < 5; r++) begin
      wr(vip_pkg::REG_CTRL, r);
      rd(vip_pkg::REG_STAT);
      idle(UNIT * mult[r] - 4);
      check({31'h0, irq}, 32'h0000_0000);
      idle(8);
      check({31'h0, irq}, 32'h0000_0001);
      rdchk(vip_pkg::REG_STAT, 32'h0000_0001);
    end
    wr(vip_pkg::REG_CTRL, 32'h0000_0005);
    rd(vip_pkg::REG_STAT);
    idle(200);
    check({31'h0, irq}, 32'h0000_0000);
    wr(vip_pkg::REG_MASK, 32'h0000_0000);
    cmd(vip_pkg::OP_QUERY, 8'h00, 16'h0000);
    idle(3);
    check({31'h0, irq}, 32'h0000_0000);
    rdchk(vip_pkg::REG_STAT, 32'h0000_0001);
    // input activity: glitch, rise, fall
    probe_in <= 8'h04;
    idle(2);
    cmd(vip_pkg::OP_QUERY, 8'h00, 16'h0000);
    idle(2);
    rd(vip_pkg::REG_STAT);
    probe_in <= 8'h07;
    idle(2);
    probe_in <= 8'h02;
    idle(2);
    cmd(vip_pkg::OP_QUERY, 8'h00, 16'h0000);
    idle(3);
    rdchk(vip_pkg::REG_VALUE, 32'h0000_0002);
    rdchk(vip_pkg::REG_SHOW, 32'h0000_00ef);
    wr(vip_pkg::REG_MASK, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0001);
    rdchk(vip_pkg::REG_STAT, 32'h0000_0003);
    check({31'h0, irq}, 32'h0000_0000);
    probe_in <= 8'h0a;
    idle(2);
    cmd(vip_pkg::OP_QUERY, 8'h00, 16'h0000);
    idle(3);
    rdchk(vip_pkg::REG_SHOW, 32'h0000_0aef);
    probe_in <= 8'h0b;
    idle(2);
    cmd(vip_pkg::OP_CLEAR, 8'h00, 16'h0000);
    cmd(vip_pkg::OP_QUERY, 8'h00, 16'h0000);
    idle(3);
    rdchk(vip_pkg::REG_SHOW, 32'h0000_0000);
    rdchk(vip_pkg::REG_VALUE, 32'h0000_000b);
    // short persistence, then back-to-back quiet samples
    probe_in <= 8'h0a;
    wr(vip_pkg::REG_CTRL, 32'h0000_0015);
    cmd(vip_pkg::OP_QUERY, 8'h00, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < (j == 0 ? 7 : 1); k++) begin
        wr(vip_pkg::REG_CMD, 32'h0000_0001);
      end
      idle(3);
      rdchk(vip_pkg::REG_SHOW, j == 0 ? 32'h0000_0003 : 32'h0);
    end
    // long persistence: shown for exactly 80 samples
    probe_in <= 8'h0b;
    wr(vip_pkg::REG_CTRL, 32'h0000_000d);
    for (int k = 0; k < 80; k++) begin
      wr(vip_pkg::REG_CMD, 32'h0000_0001);
    end
    idle(3);
    rdchk(vip_pkg::REG_SHOW, 32'h0000_0005);
    wr(vip_pkg::REG_CMD, 32'h0000_0001);
    idle(3);
    rdchk(vip_pkg::REG_SHOW, 32'h0000_0000);
    // outputs: set and button levels
    for (int d = 0; d < 8; d++) begin
      cmd(vip_pkg::OP_SET, 8'h03, 16'(d));
      exp_b = d[1] ? d[0] ^ d[2] : d[0];
      check({31'h0, probe_out[3]}, {31'h0, exp_b});
    end
    cmd(vip_pkg::OP_UPDATE, 8'h00, 16'h0025);
    check({24'h0, probe_out}, 32'h0000_0025);
    cmd(vip_pkg::OP_LOAD, 8'h01, SEQ);
    cmd(vip_pkg::OP_LOAD, 8'h07, 16'hffff);
    cmd(vip_pkg::OP_RUN, 8'h00, 16'h0082);
    idle(1);
    for (int k = 0; k < 16; k++) begin
      check({24'h0, probe_out & 8'h82}, {30'h0, SEQ[k], 1'b0});
      idle(1);
    end
    idle(4);
    check({24'h0, probe_out & 8'h82}, 32'h0000_0002);
    cmd(vip_pkg::OP_UPDATE, 8'h00, 16'h0000);
    check({24'h0, probe_out}, 32'h0000_0002);
    cmd(vip_pkg::OP_PULSE, 8'h00, 16'h0090);
    check({24'h0, probe_out}, 32'h0000_0012);
    idle(1);
    check({24'h0, probe_out}, 32'h0000_0002);
    idle(4);
    check({24'h0, probe_out}, 32'h0000_0002);
    cmd(vip_pkg::OP_RESET, 8'h00, 16'h0000);
    check({24'h0, probe_out}, 32'h0000_0000);
    cmd(vip_pkg::OP_RUN, 8'h00, 16'h0002);
    idle(18);
    check({24'h0, probe_out}, 32'h0000_0000);
    stop_test();
  end

  // a hang is cut short well past the expected run length
  initial begin
    #400000;
    failures++;
    stop_test();
  end
endmodule
